// [src/contact_input_binder.sv]
// One binding slot: picks the contact input named by a binding code
`timescale 1ns/10ps
module contact_input_binder
  import contact_io_pkg::*;
(
  // Binding code
  input  wire logic [15:0] code,
  // Sampled inputs and their rising transitions
  input  wire logic [7:0]  level,
  input  wire logic [7:0]  rise,
  // Selected input
  output logic             bound_level,
  output logic             bound_rise
);

  logic [15:0] offset;
  logic        valid;

  always_comb begin
    offset = code - CODE_IN_FIRST;
    valid  = (code >= CODE_IN_FIRST) && (code <= CODE_IN_LAST);
    bound_level = valid ? level[offset[2:0]] : 1'b0;
    bound_rise  = valid ? rise[offset[2:0]]  : 1'b0;
  end

endmodule

// [src/contact_io_function_routing.sv]
// Contact output flag routing and contact input function binding
// Functional notes
// - Each of seven outputs carries the flag its code picks; zero means none.
// - 5705 PV event 1, 5706 PV event 2, 5689 alarm 1; defaults outs 1-3.
// - 5129,5130,5131,5133 time events 1-4; defaults outs 4-7.
// - Input functions bind by codes 5161..5168; zero binds nothing.
// - Start, stop, local, hold, advance fire only on OFF-to-ON.
// - Loop-1 auto while bound input ON, manual while OFF.
// - Pattern number is five bound bits; defaults inputs 1-4 and 8.
// - Default: input 5 starts, input 6 stops, others except the pattern bits unbound.
// - Four message displays bind the same way, default none.
//
// Decided for this implementation: the register offsets and strobed register access.
`timescale 1ns/10ps
module contact_io_function_routing
  import contact_io_pkg::*;
#(
  parameter int unsigned SAMPLE_CYCLES = SAMPLE_CYCLES_DEF
)(
  // Clock and reset
  input  wire logic             core_clk,
  input  wire logic             arst_n,
  // Register port
  input  wire logic [4:0]       reg_addr,
  input  wire logic [15:0]      reg_wdata,
  input  wire logic             reg_wr,
  input  wire logic             reg_rd,
  output logic      [15:0]      reg_rdata,
  // Internal controller flags
  input  wire int_flags_s       flags,
  // Contact pins
  input  wire logic [7:0]       contact_in,
  output logic      [6:0]       contact_out,
  // Program control functions
  output functions_s            functions
);

  logic [NUM_OUTS-1:0][15:0] out_sel_ff;
  logic [NUM_BIND-1:0][15:0] bind_ff;
  logic [7:0]                sync1_ff;
  logic [7:0]                sync2_ff;
  logic [7:0]                samp_ff;
  logic [31:0]               cnt_ff;
  logic                      tick;
  logic [7:0]                rise;
  logic [NUM_BIND-1:0]       bl;
  logic [NUM_BIND-1:0]       br;
  logic [6:0]                nxt_out;
  logic [6:0]                out_ff;
  functions_s                nxt_fn;
  functions_s                fn_ff;
  logic [15:0]               rdata_ff;

  assign contact_out = out_ff;
  assign functions   = fn_ff;
  assign reg_rdata   = rdata_ff;

  // Register writes
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_sel_ff <= OUT_SEL_RESET;
      bind_ff    <= BIND_RESET;
    end else if (reg_wr) begin
      if (reg_addr < ADDR_BIND_BASE) begin
        out_sel_ff[reg_addr[2:0]] <= reg_wdata;
      end else if (reg_addr < ADDR_IN_STATUS) begin
        bind_ff[4'(reg_addr - ADDR_BIND_BASE)] <= reg_wdata;
      end
    end
  end

  // Register reads, data valid the cycle after the strobe
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      rdata_ff <= 16'h0000;
    end else if (reg_rd) begin
      if (reg_addr < ADDR_BIND_BASE) begin
        rdata_ff <= out_sel_ff[reg_addr[2:0]];
      end else if (reg_addr < ADDR_IN_STATUS) begin
        rdata_ff <= bind_ff[4'(reg_addr - ADDR_BIND_BASE)];
      end else if (reg_addr == ADDR_IN_STATUS) begin
        rdata_ff <= {8'h00, samp_ff};
      end else if (reg_addr == ADDR_OUT_STATUS) begin
        rdata_ff <= {9'h000, out_ff};
      end else begin
        rdata_ff <= 16'h0000;
      end
    end else begin
      rdata_ff <= 16'h0000;
    end
  end

  // Pin synchroniser
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_ff <= 8'h00;
      sync2_ff <= 8'h00;
    end else begin
      sync1_ff <= contact_in;
      sync2_ff <= sync1_ff;
    end
  end

  // Sampling period counter
  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      cnt_ff <= 32'h0000_0000;
    end else if (tick) begin
      cnt_ff <= 32'h0000_0000;
    end else begin
      cnt_ff <= cnt_ff + 32'h0000_0001;
    end
  end

  assign tick = (cnt_ff >= 32'(SAMPLE_CYCLES - 1));

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      samp_ff <= 8'h00;
    end else if (tick) begin
      samp_ff <= sync2_ff;
    end
  end

  // Rising transitions exist only in the sampling cycle
  assign rise = tick ? (sync2_ff & ~samp_ff) : 8'h00;

  genvar g;
  generate
    for (g = 0; g < NUM_BIND; g++) begin : g_bind
      contact_input_binder u_bind (
        .code        (bind_ff[g]),
        .level       (samp_ff),
        .rise        (rise),
        .bound_level (bl[g]),
        .bound_rise  (br[g])
      );
    end
  endgenerate

  always_comb begin
    nxt_fn.program_start   = br[BIND_START];
    nxt_fn.program_stop    = br[BIND_STOP];
    nxt_fn.local_start     = br[BIND_LOCAL];
    nxt_fn.hold_start      = br[BIND_HOLD];
    nxt_fn.segment_advance = br[BIND_ADVANCE];
    nxt_fn.loop1_auto      = bl[BIND_AM1];
    // pattern bits; bit 4 needs external input
    nxt_fn.pattern_number  = bl[BIND_PAT0+4:BIND_PAT0];
    nxt_fn.message_display = bl[BIND_MSG1+3:BIND_MSG1];
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      fn_ff <= '0;
    end else begin
      fn_ff <= nxt_fn;
    end
  end

  always_comb begin
    for (int i = 0; i < NUM_OUTS; i++) begin
      case (out_sel_ff[i])
        CODE_PV_EV1: nxt_out[i] = flags.pv_event1;
        CODE_PV_EV2: nxt_out[i] = flags.pv_event2;
        CODE_ALARM1: nxt_out[i] = flags.alarm1;
        CODE_TIME1:  nxt_out[i] = flags.time_event[0];
        CODE_TIME2:  nxt_out[i] = flags.time_event[1];
        CODE_TIME3:  nxt_out[i] = flags.time_event[2];
        CODE_TIME4:  nxt_out[i] = flags.time_event[3];
        default:     nxt_out[i] = 1'b0;
      endcase
    end
  end

  always_ff @(posedge core_clk or negedge arst_n) begin
    if (!arst_n) begin
      out_ff <= 7'h00;
    end else begin
      out_ff <= nxt_out;
    end
  end

  property p_out_zero_off;
    @(posedge core_clk) disable iff (!arst_n)
    (out_sel_ff[0] == CODE_NONE) |=> !out_ff[0];
  endproperty
  a_out_zero_off: assert property (p_out_zero_off)
    else $error("output with code zero is driven");

  // Sampled reset term: the release edge still loads zeros, not flags
  property p_pv_event1_route;
    @(posedge core_clk) disable iff (!arst_n)
    (arst_n && out_sel_ff[1] == CODE_PV_EV1) |=>
      (out_ff[1] == $past(flags.pv_event1));
  endproperty
  a_pv_event1_route: assert property (p_pv_event1_route)
    else $error("PV event 1 not routed to selected output");

  property p_time4_route;
    @(posedge core_clk) disable iff (!arst_n)
    (arst_n && out_sel_ff[6] == CODE_TIME4) |=>
      (out_ff[6] == $past(flags.time_event[3]));
  endproperty
  a_time4_route: assert property (p_time4_route)
    else $error("time event 4 not routed to selected output");

  property p_gap_code_off;
    @(posedge core_clk) disable iff (!arst_n)
    (out_sel_ff[3] == 16'd5132) |=> !out_ff[3];
  endproperty
  a_gap_code_off: assert property (p_gap_code_off)
    else $error("unused code 5132 drives an output");

  property p_start_on_rise;
    @(posedge core_clk) disable iff (!arst_n)
    (tick && bind_ff[BIND_START] == 16'd5165 && sync2_ff[4] && !samp_ff[4])
      |=> fn_ff.program_start ##1 !fn_ff.program_start;
  endproperty
  a_start_on_rise: assert property (p_start_on_rise)
    else $error("program start missed or longer than one cycle");

  property p_stop_no_refire;
    @(posedge core_clk) disable iff (!arst_n)
    (bind_ff[BIND_STOP] == 16'd5166 && !(tick && sync2_ff[5] && !samp_ff[5]))
      |=> !fn_ff.program_stop;
  endproperty
  a_stop_no_refire: assert property (p_stop_no_refire)
    else $error("program stop fired without a rising input");

  property p_auto_level;
    @(posedge core_clk) disable iff (!arst_n)
    (bind_ff[BIND_AM1] == 16'd5163) |=> (fn_ff.loop1_auto == $past(samp_ff[2]));
  endproperty
  a_auto_level: assert property (p_auto_level)
    else $error("auto/manual does not follow its input level");

  property p_pattern_bit4;
    @(posedge core_clk) disable iff (!arst_n)
    (bind_ff[BIND_PAT0+4] == CODE_IN_LAST) |=>
      (fn_ff.pattern_number[4] == $past(samp_ff[7]));
  endproperty
  a_pattern_bit4: assert property (p_pattern_bit4)
    else $error("pattern bit 4 does not follow input 8");

  property p_msg_unbound;
    @(posedge core_clk) disable iff (!arst_n)
    (bind_ff[BIND_MSG1] == CODE_NONE) |=> !fn_ff.message_display[0];
  endproperty
  a_msg_unbound: assert property (p_msg_unbound)
    else $error("unbound message display is active");

  property p_sample_spacing;
    @(posedge core_clk) disable iff (!arst_n)
    $changed(samp_ff) |-> $past(tick);
  endproperty
  a_sample_spacing: assert property (p_sample_spacing)
    else $error("inputs sampled outside sampling tick");

endmodule

// [src/contact_io_pkg.sv]
// Package: codes, defaults, register map and carriers for contact routing
package contact_io_pkg;

  localparam int NUM_OUTS = 7;
  localparam int NUM_INS  = 8;
  localparam int NUM_BIND = 15;

  // Output flag registration codes
  localparam logic [15:0] CODE_NONE   = 16'h0000;
  localparam logic [15:0] CODE_PV_EV1 = 16'd5705;
  localparam logic [15:0] CODE_PV_EV2 = 16'd5706;
  localparam logic [15:0] CODE_ALARM1 = 16'd5689;
  localparam logic [15:0] CODE_TIME1  = 16'd5129;
  localparam logic [15:0] CODE_TIME2  = 16'd5130;
  localparam logic [15:0] CODE_TIME3  = 16'd5131;
  localparam logic [15:0] CODE_TIME4  = 16'd5133;

  // Input binding codes, consecutive per contact input
  localparam logic [15:0] CODE_IN_FIRST = 16'd5161;
  localparam logic [15:0] CODE_IN_LAST  = 16'd5168;

  // Binding slots
  localparam int BIND_START   = 0;
  localparam int BIND_STOP    = 1;
  localparam int BIND_LOCAL   = 2;
  localparam int BIND_HOLD    = 3;
  localparam int BIND_ADVANCE = 4;
  localparam int BIND_AM1     = 5;
  localparam int BIND_PAT0    = 6;
  localparam int BIND_MSG1    = 11;

  // Reset values; element 0 is the rightmost entry
  localparam logic [NUM_OUTS-1:0][15:0] OUT_SEL_RESET = {
    CODE_TIME4, CODE_TIME3, CODE_TIME2, CODE_TIME1,
    CODE_ALARM1, CODE_PV_EV2, CODE_PV_EV1};
  localparam logic [NUM_BIND-1:0][15:0] BIND_RESET = {
    CODE_NONE, CODE_NONE, CODE_NONE, CODE_NONE,
    16'd5168, 16'd5164, 16'd5163, 16'd5162, 16'd5161,
    CODE_NONE, CODE_NONE, CODE_NONE, CODE_NONE,
    16'd5166, 16'd5165};

  // Register word indices
  localparam logic [4:0] ADDR_OUT_SEL_BASE = 5'h00;
  localparam logic [4:0] ADDR_BIND_BASE    = 5'h07;
  localparam logic [4:0] ADDR_IN_STATUS    = 5'h16;
  localparam logic [4:0] ADDR_OUT_STATUS   = 5'h17;

  // Sampling period
  localparam int unsigned CLK_FREQ_HZ      = 100_000_000;
  localparam int unsigned SAMPLE_PERIOD_MS = 200;
  localparam int unsigned SAMPLE_CYCLES_DEF =
    SAMPLE_PERIOD_MS * (CLK_FREQ_HZ / 1000);

  typedef struct packed {
    logic       pv_event1;
    logic       pv_event2;
    logic       alarm1;
    logic [3:0] time_event;
  } int_flags_s;

  typedef struct packed {
    logic       program_start;
    logic       program_stop;
    logic       local_start;
    logic       hold_start;
    logic       segment_advance;
    logic       loop1_auto;
    logic [4:0] pattern_number;
    logic [3:0] message_display;
  } functions_s;

endpackage

// [verif/contact_field_model.sv]
// Field contact set model driving the controller's contact pins
`timescale 1ns/10ps
module contact_field_model (
  // Clock
  input  wire logic       core_clk,
  // Requested switch states and pattern choice
  input  wire logic [7:0] sw,
  input  wire logic [4:0] pat,
  input  wire logic       pat_en,
  input  wire logic [1:0] lag,
  // Contact pins
  output logic      [7:0] contact_in
);
  logic [7:0] want;
  logic [1:0] cnt;
  // input 8 held ON for high patterns
  assign want = pat_en ? {pat[4], sw[6:4], pat[3:0]} : sw;
  initial begin
    contact_in = 8'h00;
    cnt = 2'h0;
  end
  // Slow relays settle up to three cycles late
  always @(posedge core_clk) begin
    if (contact_in == want) begin
      cnt <= 2'h0;
    end else if (cnt >= lag) begin
      contact_in <= want;
      cnt <= 2'h0;
    end else begin
      cnt <= cnt + 2'h1;
    end
  end
endmodule

// [verif/tb.sv]
// Self-checking bench for contact flag routing and input binding
`timescale 1ns/10ps
module tb;
  import contact_io_pkg::*;
  logic        core_clk = 1'b0;
  logic        arst_n = 1'b0;
  logic [4:0]  reg_addr = 5'h00;
  logic [15:0] reg_wdata = 16'h0000;
  logic        reg_wr = 1'b0;
  logic        reg_rd = 1'b0;
  logic [15:0] reg_rdata;
  int_flags_s  flags = '0;
  logic [7:0]  contact_in;
  logic [7:0]  sw = 8'h00;
  logic [4:0]  pat = 5'h00;
  logic        pat_en = 1'b0;
  logic [1:0]  lag = 2'h0;
  logic [6:0]  contact_out;
  functions_s  functions;
  int          n_mismatch = 0;
  int          samples_checked = 0;
  logic [15:0] bnd [NUM_BIND];
  logic [15:0] sel [NUM_OUTS];
  logic [7:0]  pins;
  logic [7:0]  old;

  always #5 core_clk = ~core_clk;

  // Short sampling period keeps the run brief
  contact_io_function_routing #(.SAMPLE_CYCLES(4)) i_dut (
    .core_clk(core_clk), .arst_n(arst_n), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .flags(flags), .contact_in(contact_in),
    .contact_out(contact_out), .functions(functions));
  contact_field_model i_field (
    .core_clk(core_clk), .sw(sw), .pat(pat), .pat_en(pat_en),
    .lag(lag), .contact_in(contact_in));

  task automatic conclude();
    $display("mismatches %0d, comparisons %0d", n_mismatch, samples_checked);
    if (n_mismatch == 0 && samples_checked > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask

  task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask

  task automatic wr(input logic [4:0] a, input logic [15:0] d);
    @(posedge core_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge core_clk);
    reg_wr <= 1'b0;
  endtask

  task automatic rd(input logic [4:0] a, input logic [15:0] exp);
    @(posedge core_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge core_clk);
    reg_rd <= 1'b0;
    #1 chk(reg_rdata, exp);
  endtask

  function automatic logic flag_of(logic [15:0] c, int_flags_s f);
    case (c)
      CODE_PV_EV1: return f.pv_event1;
      CODE_PV_EV2: return f.pv_event2;
      CODE_ALARM1: return f.alarm1;
      CODE_TIME1:  return f.time_event[0];
      CODE_TIME2:  return f.time_event[1];
      CODE_TIME3:  return f.time_event[2];
      CODE_TIME4:  return f.time_event[3];
      default:     return 1'b0;
    endcase
  endfunction

  function automatic logic bit_of(logic [15:0] c, logic [7:0] p);
    if (c < CODE_IN_FIRST || c > CODE_IN_LAST)
      return 1'b0;
    return p[3'(c - CODE_IN_FIRST)];
  endfunction

  // Counts pulses over four sample periods, then checks every function
  task automatic observe();
    logic [15:0] pulses [5];
    logic [4:0]  ep;
    logic [3:0]  em;
    pulses = '{default: 16'h0000};
    repeat (16) begin
      @(posedge core_clk);
      #1;
      for (int j = 0; j < 5; j++)
        pulses[j] += 16'(functions[14-j]);
    end
    for (int j = 0; j < 5; j++)
      chk(pulses[j], 16'(bit_of(bnd[j], pins & ~old)));
    chk(16'(functions.loop1_auto), 16'(bit_of(bnd[BIND_AM1], pins)));
    for (int j = 0; j < 5; j++)
      ep[j] = bit_of(bnd[BIND_PAT0+j], pins);
    for (int j = 0; j < 4; j++)
      em[j] = bit_of(bnd[BIND_MSG1+j], pins);
    chk(16'(functions.pattern_number), 16'(ep));
    chk(16'(functions.message_display), 16'(em));
    rd(ADDR_IN_STATUS, 16'(pins));
    old = pins;
  endtask

  initial begin
    logic [15:0] codes [9];
    logic [6:0]  exp_o;
    codes = '{CODE_PV_EV1, CODE_PV_EV2, CODE_ALARM1, CODE_TIME1,
              CODE_TIME2, CODE_TIME3, CODE_TIME4, CODE_NONE, 16'd5132};
    void'($urandom(32'h9532939A));
    repeat (20) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < NUM_OUTS; i++) begin
      sel[i] = OUT_SEL_RESET[i];
      rd(ADDR_OUT_SEL_BASE + 5'(i), sel[i]);
    end
    for (int i = 0; i < NUM_BIND; i++) begin
      bnd[i] = BIND_RESET[i];
      rd(ADDR_BIND_BASE + 5'(i), bnd[i]);
    end
    for (int o = 0; o < NUM_OUTS; o++)
      for (int k = 0; k < 9; k++) begin
        sel[o] = codes[k];
        wr(ADDR_OUT_SEL_BASE + 5'(o), sel[o]);
        flags <= int_flags_s'(7'($urandom));
        repeat (2) @(posedge core_clk);
        #1;
        for (int j = 0; j < NUM_OUTS; j++)
          exp_o[j] = flag_of(sel[j], flags);
        chk(16'(contact_out), 16'(exp_o));
      end
    rd(ADDR_OUT_STATUS, 16'(exp_o));
    wr(ADDR_IN_STATUS, 16'hFFFF);
    rd(ADDR_IN_STATUS, 16'h0000);
    rd(5'h1F, 16'h0000);
    old = 8'h00;
    for (int t = 0; t < 40; t++) begin
      if (t >= 8)
        for (int s = 0; s < NUM_BIND; s++) begin
          case ($urandom_range(0, 9))
            0: bnd[s] = CODE_NONE;
            1: bnd[s] = 16'd5169;
            default: bnd[s] = CODE_IN_FIRST + 16'($urandom_range(0, 7));
          endcase
          wr(ADDR_BIND_BASE + 5'(s), bnd[s]);
        end
      @(posedge core_clk);
      sw <= 8'($urandom);
      pat <= 5'($urandom);
      lag <= 2'($urandom);
      pat_en <= (t < 8);
      #1;
      pins = pat_en ? {pat[4], sw[6:4], pat[3:0]} : sw;
      observe();
    end
    // Second reset with contacts held: every ON input counts as a rise
    @(posedge core_clk);
    sw <= 8'hFF;
    pins = 8'hFF;
    repeat (16) @(posedge core_clk);
    arst_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    arst_n <= 1'b1;
    for (int i = 0; i < NUM_BIND; i++)
      bnd[i] = BIND_RESET[i];
    old = 8'h00;
    observe();
    rd(ADDR_OUT_SEL_BASE, CODE_PV_EV1);
    conclude();
  end

  initial begin
    repeat (20000) @(posedge core_clk);
    n_mismatch++;
    conclude();
  end
endmodule
